//--- tavp_division.sv
// one division: 2oo4 voting unit, 2oo3 interface unit, priority outputs, monitor slave
`timescale 1ns/100ps
`default_nettype none
module tavp_division
  import tavp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = LINK_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // separation group demands into the voting unit
  input wire logic [N_GROUPS-1:0] grp_strobe,
  input wire logic [N_GROUPS-1:0] grp_err,
  input wire logic [N_GROUPS-1:0] grp_trip,
  input wire logic [N_GROUPS-1:0] grp_sf,
  // voting unit results towards the interface units
  output logic vote_trip,
  output logic vote_sf,
  output logic vote_alarm,
  // redundant safety data lanes into the interface unit
  input wire logic [N_LANES-1:0] lane_strobe,
  input wire logic [N_LANES-1:0] lane_err,
  input wire logic [N_LANES-1:0] lane_trip,
  input wire logic [N_LANES-1:0] lane_sf,
  output logic lane_alarm,
  // hardwired inputs (pins, asynchronous)
  input wire logic manual_trip,
  input wire logic manual_sf,
  input wire logic ns_enable,
  input wire logic [N_OUTS-1:0] ns_energize,
  input wire logic [1:0] breaker_closed,
  input wire logic [3:0] equip_fb,
  // de-energize-to-trip outputs
  output logic rtb_uv,
  output logic rtb_shunt,
  output logic phb_uv,
  output logic phb_shunt,
  output logic [3:0] sol_switch,
  // monitor bus slave
  input wire logic mon_req,
  input wire logic [1:0] mon_sel,
  input wire logic mon_err,
  output logic mon_ack,
  output logic [MON_W-1:0] mon_data,
  output logic mon_alarm
);
  import tavp_pkg::*;

  ////////////////////////////////////////////////////////////////
  // types and state

  // one watched data link: last payload, validity, silence timer
  typedef struct packed {
    logic valid;
    logic trip;
    logic sf;
    logic [LINK_CNT_W-1:0] quiet;
  } tavp_link_s;

  typedef struct packed {
    tavp_link_s [N_GROUPS-1:0] grp; // voting unit inputs
    tavp_link_s [N_LANES-1:0] lane; // interface unit lanes
    logic vote_trip; // 2oo4 trip result
    logic vote_sf; // 2oo4 feature result
    logic vote_alarm; // a group link is down
    logic eiu_trip; // 2oo3 trip result
    logic eiu_sf; // 2oo3 feature result
    logic lane_alarm; // a lane is down
    logic [13:0] pin_s1; // first synchroniser stage
    logic [13:0] pin_s2; // second synchroniser stage
    logic mon_fail; // monitor bus failed, stay silent
    logic mon_ack; // answer strobe
    logic [MON_W-1:0] mon_data; // answer word
  } tavp_div_s;

  tavp_div_s st; // registered state
  tavp_div_s next_st; // next state

  // reset image: every link invalid and every vote already demanding, so
  // the output stages never see a calm vote in the cycles after reset
  localparam tavp_div_s DIV_RESET = '{
    vote_trip: 1'b1,
    vote_sf: 1'b1,
    eiu_trip: 1'b1,
    eiu_sf: 1'b1,
    default: '0
  };

  // synchronised pin views, read only from the second stage
  logic s_manual_trip;
  logic s_manual_sf;
  logic s_ns_enable;
  logic [N_OUTS-1:0] s_ns_energize;
  logic [1:0] s_breaker;
  logic [3:0] s_equip;

  // priority logic results
  logic [N_OUTS-1:0] out_energize;
  tavp_src_e [N_OUTS-1:0] out_source;
  logic [N_OUTS-1:0] dig_dmd;
  logic [N_OUTS-1:0] man_dmd;

  ////////////////////////////////////////////////////////////////
  // helpers

  // advance one link watchdog; silence or error means invalid
  function automatic tavp_link_s link_step(input tavp_link_s cur, input logic strobe,
                                           input logic err, input logic trip, input logic sf,
                                           input logic [LINK_CNT_W-1:0] limit);
    tavp_link_s nxt;
    nxt = cur;
    if (err) begin
      // error wins over a strobe in the same cycle
      nxt.valid = 1'b0;
      nxt.quiet = '0;
    end else if (strobe) begin
      // fresh frame: take payload, restart the silence timer
      nxt.valid = 1'b1;
      nxt.trip = trip;
      nxt.sf = sf;
      nxt.quiet = '0;
    end else if (cur.quiet >= limit) begin
      // silent too long: the old payload is no longer trusted
      nxt.valid = 1'b0;
    end else begin
      // still inside the silence limit
      nxt.quiet = cur.quiet + 1'b1;
    end
    return nxt;
  endfunction

  // a link that is not valid demands, whatever it last carried
  function automatic logic link_dmd(input logic valid, input logic flag);
    return !valid || flag;
  endfunction

  // population count of up to four demand bits
  function automatic logic [2:0] count4(input logic [3:0] v);
    return {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
  endfunction

  ////////////////////////////////////////////////////////////////
  // pin synchroniser outputs

  assign s_manual_trip = st.pin_s2[0];
  assign s_manual_sf = st.pin_s2[1];
  assign s_ns_enable = st.pin_s2[2];
  assign s_breaker = st.pin_s2[4:3];
  assign s_equip = st.pin_s2[8:5];
  // nonsafety commands are wide, kept in their own stages below
  logic [N_OUTS-1:0] ns_s1;
  logic [N_OUTS-1:0] ns_s2;
  assign s_ns_energize = ns_s2;

  // second pair of flops for nonsafety command pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ns_s1 <= '0;
      ns_s2 <= '0;
    end else begin
      ns_s1 <= ns_energize;
      ns_s2 <= ns_s1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [3:0] g_trip;
    logic [3:0] g_sf;
    logic [1:0] l_trip_n;
    logic [1:0] l_sf_n;
    logic [MON_W-1:0] word;
    g_trip = '0;
    g_sf = '0;
    l_trip_n = '0;
    l_sf_n = '0;
    word = '0;
    next_st = st;

    // two-flop synchronisers for hardwired pins
    next_st.pin_s1 = {5'h00, equip_fb, breaker_closed, ns_enable, manual_sf, manual_trip};
    next_st.pin_s2 = st.pin_s1;

    // group links into the voting unit; arrival is via bypass units
    for (int g = 0; g < N_GROUPS; g++) begin
      next_st.grp[g] = link_step(st.grp[g], grp_strobe[g], grp_err[g], grp_trip[g],
                                 grp_sf[g], LINK_CNT_W'(TIMEOUT_CYC));
      // a failed group link counts as a demand
      g_trip[g] = link_dmd(st.grp[g].valid, st.grp[g].trip);
      g_sf[g] = link_dmd(st.grp[g].valid, st.grp[g].sf);
    end

    // two-out-of-four coincidence
    next_st.vote_trip = count4(g_trip) >= VOTE_2OO4;
    next_st.vote_sf = count4(g_sf) >= VOTE_2OO4;
    // alarm while any group link is down
    next_st.vote_alarm = !(&{st.grp[3].valid, st.grp[2].valid, st.grp[1].valid, st.grp[0].valid});

    // redundant lanes into the interface unit, slave side only
    for (int l = 0; l < N_LANES; l++) begin
      next_st.lane[l] = link_step(st.lane[l], lane_strobe[l], lane_err[l], lane_trip[l],
                                  lane_sf[l], LINK_CNT_W'(TIMEOUT_CYC));
      // lane failure is fail-safe: it demands
      l_trip_n = l_trip_n + {1'b0, link_dmd(st.lane[l].valid, st.lane[l].trip)};
      l_sf_n = l_sf_n + {1'b0, link_dmd(st.lane[l].valid, st.lane[l].sf)};
    end

    // two-out-of-three on the lanes
    next_st.eiu_trip = l_trip_n >= VOTE_2OO3;
    next_st.eiu_sf = l_sf_n >= VOTE_2OO3;
    // alarm on any lane failure
    next_st.lane_alarm = !(&{st.lane[2].valid, st.lane[1].valid, st.lane[0].valid});

    // monitor bus failure latches until reset
    // only a reset clears it; a flaky bus is not trusted again
    if (mon_err) begin
      next_st.mon_fail = 1'b1;
    end

    // status words for the monitor bus
    if (mon_sel == MON_SEL_LINKS) begin
      // link validity, votes and alarms; bits 15 and 14 spare
      word = {2'h0,
              st.mon_fail,
              st.lane_alarm,
              st.vote_alarm,
              st.eiu_sf,
              st.eiu_trip,
              st.vote_sf,
              st.vote_trip,
              st.lane[2].valid, st.lane[1].valid, st.lane[0].valid,
              st.grp[3].valid, st.grp[2].valid, st.grp[1].valid, st.grp[0].valid};
    end else if (mon_sel == MON_SEL_BREAKER) begin
      word = {9'h000, st.lane[2].valid, st.lane[1].valid, st.lane[0].valid,
              2'h0, s_breaker};
    end else if (mon_sel == MON_SEL_EQUIP) begin
      word = {9'h000, st.lane[2].valid, st.lane[1].valid, st.lane[0].valid, s_equip};
    end else begin
      word = {8'h00, out_energize};
    end

    // answer only when asked and never after a bus failure
    next_st.mon_ack = mon_req && !st.mon_fail && !mon_err;
    next_st.mon_data = next_st.mon_ack ? word : '0;
  end

  ////////////////////////////////////////////////////////////////
  // state register; reset starts every link invalid, so all demand
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= DIV_RESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////
  // priority actuation per output; each has its own instance, so
  // the undervoltage and shunt paths share no priority logic

  // rtb breaker paths follow the trip vote, the rest (phb paths and solenoid switches) the feature vote
  always_comb begin
    // defaults keep the process free of latches
    dig_dmd = '0;
    man_dmd = '0;
    for (int o = 0; o < N_OUTS; o++) begin
      if (OUT_IS_TRIP[o]) begin
        // both breaker paths see the same trip demand
        dig_dmd[o] = st.eiu_trip;
        man_dmd[o] = s_manual_trip;
      end else begin
        // heater breakers and solenoid switches on the feature
        dig_dmd[o] = st.eiu_sf;
        man_dmd[o] = s_manual_sf;
      end
    end
  end

  // one discrete priority stage per output device
  // a second division unit drives the same component in parallel, so
  // pulling this one does not by itself actuate the component
  genvar gi;
  generate
    for (gi = 0; gi < N_OUTS; gi++) begin : g_out
      tavp_priority_logic u_prio (
        .clk(clk),
        .sys_rst(sys_rst),
        .digital_dmd(dig_dmd[gi]),
        .manual_dmd(man_dmd[gi]),
        .ns_enable(s_ns_enable),
        .ns_energize(s_ns_energize[gi]),
        .energize(out_energize[gi]),
        .source(out_source[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  // votes and link alarms
  assign vote_trip = st.vote_trip;
  assign vote_sf = st.vote_sf;
  assign vote_alarm = st.vote_alarm;
  assign lane_alarm = st.lane_alarm;
  // monitor slave
  assign mon_ack = st.mon_ack;
  assign mon_data = st.mon_data;
  assign mon_alarm = st.mon_fail;
  // breaker paths and solenoid switches, from the priority flops
  assign rtb_uv = out_energize[OUT_RTB_UV];
  assign rtb_shunt = out_energize[OUT_RTB_SHUNT];
  assign phb_uv = out_energize[OUT_PHB_UV];
  assign phb_shunt = out_energize[OUT_PHB_SHUNT];
  assign sol_switch = out_energize[OUT_SOL_FIRST +: 4];
endmodule
`default_nettype wire

//--- tavp_division_asserts.sv
// port checker for the division voting and priority block
`timescale 1ns/100ps
`default_nettype none
module tavp_division_asserts
  import tavp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link inputs
  input wire logic [N_GROUPS-1:0] grp_strobe,
  input wire logic [N_GROUPS-1:0] grp_err,
  input wire logic [N_GROUPS-1:0] grp_trip,
  input wire logic [N_GROUPS-1:0] grp_sf,
  input wire logic [N_LANES-1:0] lane_strobe,
  input wire logic [N_LANES-1:0] lane_err,
  input wire logic [N_LANES-1:0] lane_trip,
  input wire logic [N_LANES-1:0] lane_sf,
  // hardwired pins
  input wire logic manual_trip,
  input wire logic manual_sf,
  input wire logic ns_enable,
  input wire logic [N_OUTS-1:0] ns_energize,
  // results
  input wire logic vote_trip,
  input wire logic vote_sf,
  input wire logic rtb_uv,
  input wire logic rtb_shunt,
  input wire logic phb_uv,
  input wire logic phb_shunt,
  input wire logic [3:0] sol_switch,
  // monitor bus
  input wire logic mon_req,
  input wire logic mon_err,
  input wire logic mon_ack,
  input wire logic mon_alarm
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // every link framed cleanly in one cycle
  wire logic grp_ok = &grp_strobe && !(|grp_err);
  wire logic lane_ok = &lane_strobe && !(|lane_err);
  wire logic [7:0] outs = {sol_switch, phb_shunt, phb_uv, rtb_shunt, rtb_uv};
  ////////////////////////////////////////
  vote_trip_a: assert property (
    grp_ok && $countones(grp_trip) >= 2 |-> ##2 vote_trip) else $error("2oo4 trip missed");
  vote_sf_a: assert property (
    grp_ok && $countones(grp_sf) >= 2 |-> ##2 vote_sf) else $error("2oo4 actuation missed");
  vote_quiet_a: assert property (
    grp_ok && $countones(grp_trip) < 2 |-> ##2 !vote_trip) else $error("spurious vote trip");
  lane_trip_a: assert property (
    lane_ok && $countones(lane_trip) >= 2 |-> ##3 !rtb_uv && !rtb_shunt) else $error("2oo3 trip missed");
  lane_sf_a: assert property (
    lane_ok && $countones(lane_sf) >= 2 |-> ##3 outs[7:2] == 6'h00) else $error("actuation missed");
  manual_trip_a: assert property (
    manual_trip [*5] |-> !rtb_uv && !rtb_shunt) else $error("manual trip ignored");
  manual_sf_a: assert property (
    manual_sf [*5] |-> outs[7:2] == 6'h00) else $error("manual actuation ignored");
  ns_hold_a: assert property (
    (ns_enable && ns_energize == 8'h00) [*5] |-> outs == 8'h00) else $error("nonsafety command lost");
  mon_slave_a: assert property (
    mon_ack |-> $past(mon_req)) else $error("unrequested answer");
  mon_mute_a: assert property (
    mon_alarm |=> !mon_ack) else $error("answer after bus failure");
  reset_safe_a: assert property (
    $fell(sys_rst) |-> (outs == 8'h00) [*3]) else $error("outputs energized at reset");
  // main scenarios reached
  cover property (grp_ok && $countones(grp_trip) >= 2);
  cover property (mon_ack);
  cover property (mon_alarm && mon_req);
endmodule
`default_nettype wire

//--- tavp_division_tb.sv
// self-checking bench for the division voting and priority block
`timescale 1ns/100ps
`default_nettype none
module tavp_division_tb;
  import tavp_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  // link model commands
  logic grp_run = 1'b0;
  logic lane_run = 1'b0;
  logic [3:0] g_trip = '0, g_sf = '0, g_err = '0;
  logic [2:0] l_trip = '0, l_sf = '0, l_err = '0;
  // pins and monitor bus
  logic manual_trip = 1'b0, manual_sf = 1'b0, ns_enable = 1'b0, mon_req = 1'b0, mon_err = 1'b0;
  logic [7:0] ns_energize = '0;
  logic [1:0] breaker_closed = 2'h2, mon_sel = 2'h0;
  logic [3:0] equip_fb = 4'h9;
  wire logic [3:0] grp_strobe, grp_err, grp_trip, grp_sf, sol_switch;
  wire logic [2:0] lane_strobe, lane_err, lane_trip, lane_sf;
  wire logic vote_trip, vote_sf, vote_alarm, lane_alarm, rtb_uv, rtb_shunt, phb_uv, phb_shunt, mon_ack, mon_alarm;
  wire logic [15:0] mon_data;
  wire logic [7:0] outs = {sol_switch, phb_shunt, phb_uv, rtb_shunt, rtb_uv};
  int error_cnt = 0;
  int check_count = 0;
  tavp_link_model #(.W(4), .GAP(8)) grp_src (.clk(clk), .run(grp_run), .dmd_trip(g_trip), .dmd_sf(g_sf),
    .dmd_err(g_err), .strobe(grp_strobe), .err(grp_err), .trip(grp_trip), .sf(grp_sf));
  tavp_link_model #(.W(3), .GAP(8)) lane_src (.clk(clk), .run(lane_run), .dmd_trip(l_trip), .dmd_sf(l_sf),
    .dmd_err(l_err), .strobe(lane_strobe), .err(lane_err), .trip(lane_trip), .sf(lane_sf));
  // short silence limit keeps the link failure test brief
  tavp_division #(.TIMEOUT_CYC(20)) uut (.clk(clk), .sys_rst(sys_rst), .grp_strobe(grp_strobe),
    .grp_err(grp_err), .grp_trip(grp_trip), .grp_sf(grp_sf), .vote_trip(vote_trip), .vote_sf(vote_sf),
    .vote_alarm(vote_alarm), .lane_strobe(lane_strobe), .lane_err(lane_err), .lane_trip(lane_trip),
    .lane_sf(lane_sf), .lane_alarm(lane_alarm), .manual_trip(manual_trip), .manual_sf(manual_sf),
    .ns_enable(ns_enable), .ns_energize(ns_energize), .breaker_closed(breaker_closed), .equip_fb(equip_fb),
    .rtb_uv(rtb_uv), .rtb_shunt(rtb_shunt), .phb_uv(phb_uv), .phb_shunt(phb_shunt), .sol_switch(sol_switch),
    .mon_req(mon_req), .mon_sel(mon_sel), .mon_err(mon_err), .mon_ack(mon_ack), .mon_data(mon_data),
    .mon_alarm(mon_alarm));
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // long enough for one frame plus the pin synchronisers
  task automatic settle();
    repeat (16) @(posedge clk);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({vote_trip, outs}, {1'b1, 8'h00});
    @(posedge clk);
    grp_run <= 1'b1;
    lane_run <= 1'b1;
    settle();
    check({vote_alarm, lane_alarm, vote_trip, outs}, {3'h0, 8'hFF});
    $display("test reset done");
  endtask
  task automatic t_vote();
    for (int p = 0; p < 16; p++) begin
      @(posedge clk);
      g_trip <= p[3:0];
      g_sf <= ~p[3:0];
      settle();
      check({vote_trip, vote_sf}, {$countones(p[3:0]) >= 2, $countones(~p[3:0]) >= 2});
    end
    @(posedge clk);
    g_trip <= '0;
    g_sf <= '0;
    $display("test vote done");
  endtask
  task automatic t_lane();
    for (int p = 0; p < 8; p++) begin
      @(posedge clk);
      l_trip <= p[2:0];
      l_sf <= ~p[2:0];
      settle();
      check(outs, {{6{$countones(~p[2:0]) < 2}}, {2{$countones(p[2:0]) < 2}}});
    end
    @(posedge clk);
    l_trip <= '0;
    l_sf <= '0;
    $display("test lane done");
  endtask
  task automatic t_priority();
    @(posedge clk);
    manual_trip <= 1'b1;
    settle();
    check(outs, 8'hFC);
    @(posedge clk);
    manual_trip <= 1'b0;
    manual_sf <= 1'b1;
    ns_enable <= 1'b1;
    ns_energize <= 8'hFF;
    settle();
    check(outs, 8'h03);
    @(posedge clk);
    manual_sf <= 1'b0;
    ns_energize <= 8'hA5;
    settle();
    check(outs, 8'hA5);
    @(posedge clk);
    ns_energize <= 8'h00;
    settle();
    check(outs, 8'h00);
    @(posedge clk);
    ns_energize <= 8'hFF;
    l_trip <= 3'h6;
    settle();
    check(outs, 8'hFC);
    @(posedge clk);
    ns_enable <= 1'b0;
    ns_energize <= 8'h5A;
    l_trip <= 3'h0;
    settle();
    check(outs, 8'hFF);
    $display("test priority done");
  endtask
  task automatic t_fail();
    @(posedge clk);
    l_err <= 3'h1;
    settle();
    check({lane_alarm, outs}, {1'b1, 8'hFF});
    @(posedge clk);
    l_err <= 3'h3;
    settle();
    check({lane_alarm, outs}, {1'b1, 8'h00});
    @(posedge clk);
    l_err <= 3'h0;
    grp_run <= 1'b0;
    settle();
    settle();
    check({lane_alarm, vote_alarm, vote_trip, vote_sf, outs}, {4'h7, 8'hFF});
    @(posedge clk);
    grp_run <= 1'b1;
    settle();
    check({vote_alarm, vote_trip, vote_sf}, 3'h0);
    @(posedge clk);
    g_err <= 4'h1;
    settle();
    check({vote_alarm, vote_trip, vote_sf}, 3'h4);
    @(posedge clk);
    g_err <= 4'h0;
    settle();
    $display("test fail done");
  endtask
  // one monitor request pulse, answer looked at in its single cycle
  task automatic mon_read(input logic [1:0] sel, input logic ack, input logic [15:0] data);
    @(posedge clk);
    mon_req <= 1'b1;
    mon_sel <= sel;
    @(posedge clk);
    mon_req <= 1'b0;
    #1;
    check({mon_ack, mon_data}, {ack, data});
  endtask
  task automatic t_mon();
    mon_read(2'h0, 1'b1, 16'h007F);
    mon_read(2'h1, 1'b1, 16'h0072);
    mon_read(2'h2, 1'b1, 16'h0079);
    mon_read(2'h3, 1'b1, 16'h00FF);
    @(posedge clk);
    mon_err <= 1'b1;
    @(posedge clk);
    mon_err <= 1'b0;
    settle();
    check(mon_alarm, 1'b1);
    mon_read(2'h1, 1'b0, 16'h0000);
    $display("test monitor done");
  endtask
  ////////////////////////////////////////
  initial begin
    t_reset();
    t_vote();
    t_lane();
    t_priority();
    t_fail();
    t_mon();
    test_done();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t run timed out", $time);
    test_done();
  end
endmodule
bind tavp_division tavp_division_asserts u_chk (.clk, .sys_rst, .grp_strobe, .grp_err, .grp_trip, .grp_sf,
  .lane_strobe, .lane_err, .lane_trip, .lane_sf, .manual_trip, .manual_sf, .ns_enable, .ns_energize,
  .vote_trip, .vote_sf, .rtb_uv, .rtb_shunt, .phb_uv, .phb_shunt, .sol_switch, .mon_req, .mon_err,
  .mon_ack, .mon_alarm);
`default_nettype wire

//--- tavp_link_model.sv
// bypass unit model: repeats framed demands on a group of safety data links
`timescale 1ns/100ps
`default_nettype none
module tavp_link_model #(
  parameter int W = 4,
  parameter int GAP = 8
) (
  // clock
  input wire logic clk,
  // demands commanded by the bench
  input wire logic run,
  input wire logic [W-1:0] dmd_trip,
  input wire logic [W-1:0] dmd_sf,
  input wire logic [W-1:0] dmd_err,
  // link lines
  output logic [W-1:0] strobe,
  output logic [W-1:0] err,
  output logic [W-1:0] trip,
  output logic [W-1:0] sf
);
  int cnt = 0; // frame spacing, kept below the silence limit
  ////////////////////////////////////////
  // one frame every GAP cycles while running
  always @(posedge clk) begin
    cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
    if (run && cnt == 0) begin
      strobe <= '1;
      err <= dmd_err;
      trip <= dmd_trip;
      sf <= dmd_sf;
    end else begin
      // payload outside a frame is not held, so flip it
      strobe <= '0;
      err <= '0;
      trip <= ~trip;
      sf <= ~sf;
    end
  end
endmodule
`default_nettype wire

//--- tavp_pkg.sv
// shared constants for the trip actuation voting and priority block
package tavp_pkg;
  // clock rate
  localparam int unsigned CLK_PERIOD_NS = 10;
  // silence on a data link longer than this marks the link failed
  localparam int unsigned LINK_TIMEOUT_US = 1000;
  localparam int unsigned LINK_TIMEOUT_CYC = (LINK_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned LINK_CNT_W = 17;
  // voting geometry
  localparam int unsigned N_GROUPS = 4;
  localparam int unsigned N_LANES = 3;
  localparam logic [2:0] VOTE_2OO4 = 3'h2;
  localparam logic [1:0] VOTE_2OO3 = 2'h2;
  // output channel indices
  localparam int unsigned N_OUTS = 8;
  localparam int unsigned OUT_RTB_UV = 0;
  localparam int unsigned OUT_RTB_SHUNT = 1;
  localparam int unsigned OUT_PHB_UV = 2;
  localparam int unsigned OUT_PHB_SHUNT = 3;
  localparam int unsigned OUT_SOL_FIRST = 4;
  localparam logic [7:0] OUT_IS_TRIP = 8'h03;
  // monitor bus status word selects
  localparam int unsigned MON_W = 16;
  localparam logic [1:0] MON_SEL_LINKS = 2'h0;
  localparam logic [1:0] MON_SEL_BREAKER = 2'h1;
  localparam logic [1:0] MON_SEL_EQUIP = 2'h2;
  localparam logic [1:0] MON_SEL_OUTS = 2'h3;
  // reset values: de-energized, demanding
  localparam logic OUT_RESET = 1'b0;
  // command source codes reported per output
  typedef enum logic [1:0] {TAVP_SRC_NONE, TAVP_SRC_NONSAFETY, TAVP_SRC_DIGITAL, TAVP_SRC_MANUAL} tavp_src_e;
endpackage

//--- tavp_priority_logic.sv
// priority actuation logic for one de-energize-to-trip output
`timescale 1ns/100ps
`default_nettype none
module tavp_priority_logic
  import tavp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // command sources
  input wire logic digital_dmd,
  input wire logic manual_dmd,
  input wire logic ns_enable,
  input wire logic ns_energize,
  // drive to the output device
  output logic energize,
  output tavp_src_e source
);
  import tavp_pkg::*;

  typedef struct packed {
    logic energize;
    tavp_src_e source;
  } tavp_prio_s;

  tavp_prio_s st; // registered state
  tavp_prio_s next_st; // next state

  ////////////////////////////////////////////////////////////////
  // fixed priority: manual, then digital, then nonsafety
  always_comb begin
    next_st = st;
    if (manual_dmd) begin
      // manual acts whatever the digital path says
      next_st.energize = OUT_RESET;
      next_st.source = TAVP_SRC_MANUAL;
    end else if (digital_dmd) begin
      // digital vote de-energizes the device
      next_st.energize = OUT_RESET;
      next_st.source = TAVP_SRC_DIGITAL;
    end else if (ns_enable) begin
      // nonsafety only with enable and no actuation present
      next_st.energize = ns_energize;
      next_st.source = TAVP_SRC_NONSAFETY;
    end else begin
      // no demand: hold energized, device stays in service
      next_st.energize = 1'b1;
      next_st.source = TAVP_SRC_NONE;
    end
  end

  // state register; reset leaves the device de-energized
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '{energize: OUT_RESET, source: TAVP_SRC_NONE};
    end else begin
      st <= next_st;
    end
  end

  assign energize = st.energize;
  assign source = st.source;
endmodule
`default_nettype wire
